// ### deser_config_regs.sv
// Function
// - bit 7 picks low or high clock range
// - bit 6 picks lane3 colour bit order
// - bits 3:2 pick filter or legacy mode
// - bit 1 sleeps, registers kept
// - bit 0 picks registers over pins
// - register 1 bit 7 picks address source
// - respond at strap-selected one of four addresses, or at register 1 bits 6:0 when bit 7 set
// - register 2 bit 6 picks sleep state
// - bits 2:0 pick oscillator frequency
// - oscillator clock out when link lost, drive on, sleep state bit set and frequency not off
// - reset leaves pins in control
// - strap sampled while power-down held low
// - slave acks bytes, host nack ends read
`timescale 1ns/1ps
`include "deser_defs.svh"
module deser_config_regs
(
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       clk_en_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       power_down_n_i,
   input  wire logic [1:0] addr_strap_pin_i,
   input  wire logic       pin_low_freq_range_sel_i,
   input  wire logic       pin_lane_map_order_sel_i,
   input  wire logic [1:0] pin_config_mode_i,
   input  wire logic       pin_output_drive_on_i,
   input  wire logic       pin_sleep_output_state_sel_i,
   input  wire logic       pin_swing_level_sel_i,
   input  wire logic [2:0] pin_fallback_osc_freq_sel_i,
   input  wire logic       serial_clk_lost_i,
   output logic            low_freq_range_sel_o,
   output logic            lane_map_order_sel_o,
   output logic      [1:0] config_mode_o,
   output logic            sleep_o,
   output logic            output_drive_on_o,
   output logic            sleep_output_state_sel_o,
   output logic            swing_level_sel_o,
   output logic      [2:0] fallback_osc_freq_sel_o,
   output logic            osc_clock_out_en_o,
   output logic      [6:0] bus_addr_o
);

   logic [7:0] cfg_regs [0:`REG_COUNT-1];   // register storage
   logic [7:0] next_regs [0:`REG_COUNT-1];  // next register values
   logic [6:0] strap_addr;                  // address caught from strap
   logic       sda_level;                   // sampled data line
   logic       scl_rise;                    // clock line rising
   logic       scl_fall;                    // clock line falling
   logic       start_det;                   // start or repeated start
   logic       stop_det;                    // stop condition

   deser_pkg::bus_state_t state;            // slave state
   deser_pkg::bus_state_t next_state;
   logic [3:0] bit_cnt;                     // bits of current byte
   logic [3:0] next_bit_cnt;
   logic [7:0] shift_in;                    // received bits
   logic [7:0] next_shift_in;
   logic [7:0] tx_byte;                     // byte being sent
   logic [7:0] next_tx_byte;
   logic [7:0] ptr;                         // register pointer
   logic [7:0] next_ptr;
   logic       got_ptr;                     // pointer byte seen
   logic       next_got_ptr;
   logic       rw_flag;                     // read transfer
   logic       next_rw_flag;
   logic       ack_seen;                    // host acked last byte
   logic       next_ack_seen;
   logic       drive_low;                   // pull data line low
   logic       next_drive_low;
   logic       reg_wr;                      // write strobe to registers

   // line sampling and bus condition detection
   bus_line_sampler u_sampler
   (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .clk_en_i    (clk_en_i),
      .scl_i       (scl_i),
      .sda_i       (sda_i),
      .sda_level_o (sda_level),
      .scl_rise_o  (scl_rise),
      .scl_fall_o  (scl_fall),
      .start_o     (start_det),
      .stop_o      (stop_det)
   );

   // strap address capture during power-down
   strap_addr_latch u_strap
   (
      .sys_clk_i        (sys_clk_i),
      .sys_rst_i        (sys_rst_i),
      .clk_en_i         (clk_en_i),
      .power_down_n_i   (power_down_n_i),
      .addr_strap_pin_i (addr_strap_pin_i),
      .strap_addr_o     (strap_addr)
   );

   // named register views
   wire [7:0] cfg_one  = cfg_regs[0];
   wire [7:0] addr_reg = cfg_regs[1];
   wire [7:0] feat_one = cfg_regs[2];

   // address source select, bus address kept out of override
   wire [6:0] active_addr = addr_reg[`FLD_ADDR_SOURCE_SEL] ?
      addr_reg[`FLD_BUS_ADDR_HI:`FLD_BUS_ADDR_LO] : strap_addr;

   // full byte count reached
   wire byte_done = (bit_cnt == `BITS_PER_BYTE);

   // address match on the seven upper bits
   wire addr_match = (shift_in[7:1] == active_addr);

   // read data, unmapped pointers read zero
   wire [7:0] rd_data = (ptr == `REG_DEVICE_CONFIG_ONE)   ? cfg_one  :
                        (ptr == `REG_BUS_ADDRESS_SELECT)  ? addr_reg :
                        (ptr == `REG_OUTPUT_FEATURES_ONE) ? feat_one :
                                                            8'h00;

   // register override: registers or pins feed configuration
   wire override = cfg_one[`FLD_REGISTER_OVERRIDE];

   wire sel_low_freq = override ?
      cfg_one[`FLD_LOW_FREQ_RANGE_SEL] : pin_low_freq_range_sel_i;
   wire sel_lane_map = override ?
      cfg_one[`FLD_LANE_MAP_ORDER_SEL] : pin_lane_map_order_sel_i;
   wire [1:0] sel_mode = override ?
      cfg_one[`FLD_CONFIG_MODE_HI:`FLD_CONFIG_MODE_LO] :
      pin_config_mode_i;
   wire sel_drive_on = override ?
      feat_one[`FLD_OUTPUT_DRIVE_ON] : pin_output_drive_on_i;
   wire sel_sleep_state = override ?
      feat_one[`FLD_SLEEP_STATE_SEL] : pin_sleep_output_state_sel_i;
   wire sel_swing = override ?
      feat_one[`FLD_SWING_LEVEL_SEL] : pin_swing_level_sel_i;
   wire [2:0] sel_osc = override ?
      feat_one[`FLD_OSC_FREQ_HI:`FLD_OSC_FREQ_LO] :
      pin_fallback_osc_freq_sel_i;

   // sleep comes only from its register bit, unlike power-down
   wire sel_sleep = cfg_one[`FLD_SLEEP];

   // oscillator clock stands in for the lost link clock
   wire sel_osc_out = serial_clk_lost_i & sel_drive_on & sel_sleep_state &
                      (sel_osc != `OSC_FREQ_OFF);

   // slave next-state logic
   always_comb
   begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_shift_in  = shift_in;
      next_tx_byte   = tx_byte;
      next_ptr       = ptr;
      next_got_ptr   = got_ptr;
      next_rw_flag   = rw_flag;
      next_ack_seen  = ack_seen;
      next_drive_low = drive_low;
      reg_wr         = 1'b0;
      if (!power_down_n_i || stop_det)
      begin
         // powered down or stop: release the line
         next_state     = deser_pkg::BUS_IDLE;
         next_drive_low = 1'b0;
      end
      else if (start_det)
      begin
         // start or repeated start: expect an address
         next_state     = deser_pkg::BUS_ADDR;
         next_bit_cnt   = 4'h0;
         next_got_ptr   = 1'b0;
         next_drive_low = 1'b0;
      end
      else
      begin
         unique case (state)
            deser_pkg::BUS_IDLE:
               next_drive_low = 1'b0;
            deser_pkg::BUS_ADDR, deser_pkg::BUS_WRITE:
            begin
               if (scl_rise && !byte_done)
               begin
                  // shift a bit in, most significant first
                  next_shift_in = {shift_in[6:0], sda_level};
                  next_bit_cnt  = bit_cnt + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  next_bit_cnt = 4'h0;
                  if (state == deser_pkg::BUS_ADDR)
                  begin
                     if (addr_match)
                     begin
                        // ack our address
                        next_state     = deser_pkg::BUS_ADDR_ACK;
                        next_drive_low = 1'b1;
                        next_rw_flag   = shift_in[0];
                     end
                     else
                        next_state = deser_pkg::BUS_IDLE;
                  end
                  else
                  begin
                     // ack every written byte
                     next_state     = deser_pkg::BUS_WR_ACK;
                     next_drive_low = 1'b1;
                     if (got_ptr)
                     begin
                        reg_wr   = 1'b1;
                        next_ptr = ptr + 8'h01;
                     end
                     else
                     begin
                        next_ptr     = shift_in;
                        next_got_ptr = 1'b1;
                     end
                  end
               end
            end
            deser_pkg::BUS_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  if (rw_flag)
                  begin
                     // first read bit goes out right after the ack
                     next_state     = deser_pkg::BUS_READ;
                     next_tx_byte   = rd_data;
                     next_drive_low = ~rd_data[7];
                  end
                  else
                  begin
                     next_state     = deser_pkg::BUS_WRITE;
                     next_drive_low = 1'b0;
                  end
               end
            end
            deser_pkg::BUS_WR_ACK:
            begin
               if (scl_fall)
               begin
                  next_state     = deser_pkg::BUS_WRITE;
                  next_drive_low = 1'b0;
               end
            end
            deser_pkg::BUS_READ:
            begin
               if (scl_rise)
                  next_bit_cnt = bit_cnt + 4'h1;
               else if (scl_fall)
               begin
                  if (byte_done)
                  begin
                     // release for the host ack
                     next_state     = deser_pkg::BUS_RD_ACK;
                     next_drive_low = 1'b0;
                     next_bit_cnt   = 4'h0;
                     next_ptr       = ptr + 8'h01;
                  end
                  else
                  begin
                     next_tx_byte   = {tx_byte[6:0], 1'b0};
                     next_drive_low = ~tx_byte[6];
                  end
               end
            end
            deser_pkg::BUS_RD_ACK:
            begin
               if (scl_rise)
                  next_ack_seen = ~sda_level;
               else if (scl_fall)
               begin
                  if (ack_seen)
                  begin
                     // host wants another byte
                     next_state     = deser_pkg::BUS_READ;
                     next_tx_byte   = rd_data;
                     next_drive_low = ~rd_data[7];
                  end
                  else
                     next_state = deser_pkg::BUS_IDLE;
               end
            end
            default:
            begin
               // illegal code: back to idle
               next_state     = deser_pkg::BUS_IDLE;
               next_drive_low = 1'b0;
            end
         endcase
      end
   end

   // slave state registers
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         state     <= deser_pkg::BUS_IDLE;
         bit_cnt   <= 4'h0;
         shift_in  <= 8'h00;
         tx_byte   <= 8'h00;
         ptr       <= 8'h00;
         got_ptr   <= 1'b0;
         rw_flag   <= 1'b0;
         ack_seen  <= 1'b0;
         drive_low <= 1'b0;
      end
      else if (clk_en_i)
      begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         shift_in  <= next_shift_in;
         tx_byte   <= next_tx_byte;
         ptr       <= next_ptr;
         got_ptr   <= next_got_ptr;
         rw_flag   <= next_rw_flag;
         ack_seen  <= next_ack_seen;
         drive_low <= next_drive_low;
      end
   end

   // per-register write, whole byte kept including reserved bits
   genvar gi;
   generate
      for (gi = 0; gi < `REG_COUNT; gi = gi + 1)
      begin : g_reg
         localparam logic [7:0] REG_IDX = 8'(gi);
         localparam logic [7:0] REG_RST =
            (gi == 0) ? `RST_DEVICE_CONFIG_ONE :
            (gi == 1) ? `RST_BUS_ADDRESS_SELECT :
                        `RST_OUTPUT_FEATURES_ONE;
         assign next_regs[gi] = (reg_wr && ptr == REG_IDX) ?
                                shift_in : cfg_regs[gi];
         // power-down returns the register to its default
         always_ff @(posedge sys_clk_i)
         begin
            if (sys_rst_i)
               cfg_regs[gi] <= REG_RST;
            else if (clk_en_i && !power_down_n_i)
               cfg_regs[gi] <= REG_RST;
            else if (clk_en_i)
               cfg_regs[gi] <= next_regs[gi];
         end
      end
   endgenerate

   // registered outputs
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         sda_o                    <= 1'b0;
         sda_oe_o                 <= 1'b0;
         low_freq_range_sel_o     <= 1'b0;
         lane_map_order_sel_o     <= 1'b0;
         config_mode_o            <= 2'h0;
         sleep_o                  <= 1'b0;
         output_drive_on_o        <= 1'b0;
         sleep_output_state_sel_o <= 1'b0;
         swing_level_sel_o        <= 1'b0;
         fallback_osc_freq_sel_o  <= 3'h0;
         osc_clock_out_en_o       <= 1'b0;
         bus_addr_o               <= `BUS_ADDR_STRAP_3;
      end
      else if (clk_en_i)
      begin
         sda_o                    <= 1'b0;
         sda_oe_o                 <= next_drive_low;
         low_freq_range_sel_o     <= sel_low_freq;
         lane_map_order_sel_o     <= sel_lane_map;
         config_mode_o            <= sel_mode;
         sleep_o                  <= sel_sleep;
         output_drive_on_o        <= sel_drive_on;
         sleep_output_state_sel_o <= sel_sleep_state;
         swing_level_sel_o        <= sel_swing;
         fallback_osc_freq_sel_o  <= sel_osc;
         osc_clock_out_en_o       <= sel_osc_out;
         bus_addr_o               <= active_addr;
      end
   end

endmodule

// ### deser_defs.svh
`ifndef DESER_DEFS_SVH
`define DESER_DEFS_SVH

// register indices on the serial control bus
`define REG_DEVICE_CONFIG_ONE   8'h00
`define REG_BUS_ADDRESS_SELECT  8'h01
`define REG_OUTPUT_FEATURES_ONE 8'h02
`define REG_COUNT               3

// reset values of the three registers
`define RST_DEVICE_CONFIG_ONE   8'h00
`define RST_BUS_ADDRESS_SELECT  8'h70
`define RST_OUTPUT_FEATURES_ONE 8'h00

// device_config_one fields
`define FLD_LOW_FREQ_RANGE_SEL  7
`define FLD_LANE_MAP_ORDER_SEL  6
`define FLD_CONFIG_MODE_HI      3
`define FLD_CONFIG_MODE_LO      2
`define FLD_SLEEP               1
`define FLD_REGISTER_OVERRIDE   0

// bus_address_select fields
`define FLD_ADDR_SOURCE_SEL     7
`define FLD_BUS_ADDR_HI         6
`define FLD_BUS_ADDR_LO         0

// output_features_one fields
`define FLD_OUTPUT_DRIVE_ON     7
`define FLD_SLEEP_STATE_SEL     6
`define FLD_SWING_LEVEL_SEL     3
`define FLD_OSC_FREQ_HI         2
`define FLD_OSC_FREQ_LO         0

// oscillator off code
`define OSC_FREQ_OFF            3'h0

// four bus addresses chosen by the strap level code
`define BUS_ADDR_STRAP_0        7'h71
`define BUS_ADDR_STRAP_1        7'h72
`define BUS_ADDR_STRAP_2        7'h73
`define BUS_ADDR_STRAP_3        7'h76

// bits per byte on the serial control bus
`define BITS_PER_BYTE           4'h8

`endif

// ### deser_pkg.sv
package deser_pkg;

   // serial control bus slave states, gray coded along the usual path
   typedef enum logic [2:0]
   {
      BUS_IDLE     = 3'h0,
      BUS_ADDR     = 3'h1,
      BUS_ADDR_ACK = 3'h3,
      BUS_WRITE    = 3'h2,
      BUS_WR_ACK   = 3'h6,
      BUS_READ     = 3'h7,
      BUS_RD_ACK   = 3'h5
   } bus_state_t;

endpackage

// ### bus_line_sampler.sv
`timescale 1ns/1ps
module bus_line_sampler
(
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic clk_en_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_level_o,
   output logic      scl_rise_o,
   output logic      scl_fall_o,
   output logic      start_o,
   output logic      stop_o
);

   logic scl_now;   // current clock line sample
   logic sda_now;   // current data line sample
   logic scl_prev;  // clock line one cycle back
   logic sda_prev;  // data line one cycle back

   // two samples of each line, idle high after reset
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         scl_now  <= 1'b1;
         sda_now  <= 1'b1;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end
      else if (clk_en_i)
      begin
         scl_now  <= scl_i;
         sda_now  <= sda_i;
         scl_prev <= scl_now;
         sda_prev <= sda_now;
      end
   end

   // edges and bus conditions
   assign sda_level_o = sda_now;
   assign scl_rise_o  = scl_now & ~scl_prev;
   assign scl_fall_o  = ~scl_now & scl_prev;
   // data falls while clock is high
   assign start_o     = scl_now & scl_prev & sda_prev & ~sda_now;
   // data rises while clock is high
   assign stop_o      = scl_now & scl_prev & ~sda_prev & sda_now;

endmodule

// ### strap_addr_latch.sv
`timescale 1ns/1ps
`include "deser_defs.svh"
module strap_addr_latch
(
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       clk_en_i,
   input  wire logic       power_down_n_i,
   input  wire logic [1:0] addr_strap_pin_i,
   output logic      [6:0] strap_addr_o
);

   logic [6:0] decoded;  // address for the present strap level

   // strap level code to bus address
   assign decoded = (addr_strap_pin_i == 2'h0) ? `BUS_ADDR_STRAP_0 :
                    (addr_strap_pin_i == 2'h1) ? `BUS_ADDR_STRAP_1 :
                    (addr_strap_pin_i == 2'h2) ? `BUS_ADDR_STRAP_2 :
                                                 `BUS_ADDR_STRAP_3;

   // follow the strap while powered down, freeze once released
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         strap_addr_o <= `BUS_ADDR_STRAP_3;
      else if (clk_en_i && !power_down_n_i)
         strap_addr_o <= decoded;
   end

endmodule

// ### deser_config_regs_sva.sv
`timescale 1ns/1ps
module deser_config_regs_sva
(
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       scl_i,
   input  wire logic       sda_o,
   input  wire logic       sda_oe_o,
   input  wire logic       power_down_n_i,
   input  wire logic [1:0] addr_strap_pin_i,
   input  wire logic [1:0] pin_config_mode_i,
   input  wire logic       serial_clk_lost_i,
   input  wire logic [1:0] config_mode_o,
   input  wire logic       sleep_o,
   input  wire logic       output_drive_on_o,
   input  wire logic       sleep_output_state_sel_o,
   input  wire logic [2:0] fallback_osc_freq_sel_o,
   input  wire logic       osc_clock_out_en_o,
   input  wire logic [6:0] bus_addr_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // address that the strap code selects
   wire [6:0] strap_addr = (addr_strap_pin_i == 2'h0) ? 7'h71 :
                           (addr_strap_pin_i == 2'h1) ? 7'h72 :
                           (addr_strap_pin_i == 2'h2) ? 7'h73 : 7'h76;
   // fallback clock conditions all met
   wire       osc_want = serial_clk_lost_i & output_drive_on_o &
                         sleep_output_state_sel_o &
                         (fallback_osc_freq_sel_o != 3'h0);
   sda_drive_low_a : assert property (sda_o == 1'b0)
      else $error("data line driven high");
   osc_clock_on_a : assert property (osc_want [*2] |-> osc_clock_out_en_o)
      else $error("fallback clock not enabled");
   osc_clock_off_a : assert property (!osc_want [*2] |-> !osc_clock_out_en_o)
      else $error("fallback clock enabled wrongly");
   pd_pins_follow_a : assert property ((!power_down_n_i &&
      $stable(pin_config_mode_i)) [*3] |-> config_mode_o == pin_config_mode_i)
      else $error("mode not from pins in power down");
   pd_sleep_clear_a : assert property (!power_down_n_i [*3] |-> !sleep_o)
      else $error("sleep kept through power down");
   pd_bus_release_a : assert property (!power_down_n_i [*3] |-> !sda_oe_o)
      else $error("data line held in power down");
   strap_addr_a : assert property ((!power_down_n_i &&
      $stable(addr_strap_pin_i)) [*4] |-> bus_addr_o == strap_addr)
      else $error("strap address not taken");
   data_scl_low_a : assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line changed while clock high");
   reset_values_a : assert property ($fell(sys_rst_i) |->
      bus_addr_o == 7'h76 && !sda_oe_o && config_mode_o == 2'h0)
      else $error("bad values after reset");
   cover property (osc_clock_out_en_o);
   cover property ($rose(sda_oe_o));
   cover property (bus_addr_o == 7'h71);
endmodule
bind deser_config_regs deser_config_regs_sva i_sva
(
   .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .power_down_n_i(power_down_n_i),
   .addr_strap_pin_i(addr_strap_pin_i),
   .pin_config_mode_i(pin_config_mode_i),
   .serial_clk_lost_i(serial_clk_lost_i), .config_mode_o(config_mode_o),
   .sleep_o(sleep_o), .output_drive_on_o(output_drive_on_o),
   .sleep_output_state_sel_o(sleep_output_state_sel_o),
   .fallback_osc_freq_sel_o(fallback_osc_freq_sel_o),
   .osc_clock_out_en_o(osc_clock_out_en_o), .bus_addr_o(bus_addr_o)
);

// ### host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model
(
   input  wire logic sys_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_pull_o
);
   // both lines released while idle
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // third of a bit, four system clocks, above the three-clock minimum
   task automatic tick();
      repeat (4) @(negedge sys_clk_i);
   endtask
   // start or repeated start, leaves the clock low
   task automatic start();
      sda_pull_o = 1'b0;
      tick();
      scl_o = 1'b1;
      tick();
      sda_pull_o = 1'b1;
      tick();
      scl_o = 1'b0;
      tick();
   endtask
   // one bit: data set while clock low, sampled at end of high
   task automatic pulse(input logic pull, output logic seen);
      sda_pull_o = pull;
      tick();
      scl_o = 1'b1;
      tick();
      seen = sda_i;
      scl_o = 1'b0;
      tick();
   endtask
   // byte out msb first, then the slave acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         pulse(!b[i], s);
      pulse(1'b0, s);
      ack = !s;
   endtask
   // byte in, host nack only after the last byte
   task automatic recv(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         pulse(1'b0, b[i]);
      pulse(!last, s);
   endtask
   // stop, data rises while clock high
   task automatic stop();
      sda_pull_o = 1'b1;
      tick();
      scl_o = 1'b1;
      tick();
      sda_pull_o = 1'b0;
      tick();
   endtask
endmodule

// ### deser_config_regs_bench.sv
`timescale 1ns/1ps
module deser_config_regs_bench;
   logic       sys_clk, sys_rst, pd_n, lost, scl, pull, sda_o, sda_oe;
   logic       p_lf, p_map, p_drv, p_sss, p_vod;
   logic       lf, map, slp, drv, sss, vod, osc_en;
   logic [1:0] strap, p_mode, mode;
   logic [2:0] p_osc, osc;
   logic [6:0] baddr, cur;
   int         failures, n_compared;
   logic [6:0] ids [4] = '{7'h71, 7'h72, 7'h73, 7'h76};
   // wired-and data line with pull-up
   wire        sda = !(pull | (sda_oe & !sda_o));
   deser_config_regs i_dut
   (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .clk_en_i(1'b1),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .power_down_n_i(pd_n), .addr_strap_pin_i(strap),
      .pin_low_freq_range_sel_i(p_lf), .pin_lane_map_order_sel_i(p_map),
      .pin_config_mode_i(p_mode), .pin_output_drive_on_i(p_drv),
      .pin_sleep_output_state_sel_i(p_sss), .pin_swing_level_sel_i(p_vod),
      .pin_fallback_osc_freq_sel_i(p_osc), .serial_clk_lost_i(lost),
      .low_freq_range_sel_o(lf), .lane_map_order_sel_o(map),
      .config_mode_o(mode), .sleep_o(slp), .output_drive_on_o(drv),
      .sleep_output_state_sel_o(sss), .swing_level_sel_o(vod),
      .fallback_osc_freq_sel_o(osc), .osc_clock_out_en_o(osc_en),
      .bus_addr_o(baddr)
   );
   host_bus_model i_host
   (
      .sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull)
   );
   // 100 ns clock
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // compare and count
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // register write at the current bus address
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic a;
      i_host.start();
      i_host.send({cur, 1'b0}, a);
      check("ack addr", {7'h00, a}, 8'h01);
      i_host.send(idx, a);
      check("ack ptr", {7'h00, a}, 8'h01);
      i_host.send(d, a);
      check("ack data", {7'h00, a}, 8'h01);
      i_host.stop();
   endtask
   // pointer write, repeated start, one byte read
   task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                     input string what);
      logic       a;
      logic [7:0] b;
      i_host.start();
      i_host.send({cur, 1'b0}, a);
      i_host.send(idx, a);
      i_host.start();
      i_host.send({cur, 1'b1}, a);
      check("ack read", {7'h00, a}, 8'h01);
      i_host.recv(1'b1, b);
      i_host.stop();
      check(what, b, e);
   endtask
   // verdict and end of run
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      logic [7:0] d;
      failures = 0;
      n_compared = 0;
      {sys_rst, pd_n, lost, strap, cur} = {1'b1, 1'b0, 1'b0, 2'h2, 7'h73};
      {p_lf, p_map, p_mode, p_drv, p_sss, p_vod, p_osc} = '0;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (8) @(negedge sys_clk);
      pd_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      check("strap addr", {1'b0, baddr}, 8'h73);
      rd(8'h00, 8'h00, "reg0 reset");
      rd(8'h01, 8'h70, "reg1 reset");
      rd(8'h02, 8'h00, "reg2 reset");
      $display("test reset done");
      {p_lf, p_map, p_mode, p_drv, p_sss, p_osc} = {6'h3F, 3'h5};
      lost = 1'b1;
      repeat (4) @(negedge sys_clk);
      check("pin mode", {6'h00, mode}, 8'h03);
      check("pin osc", {7'h00, osc_en}, 8'h01);
      $display("test pins done");
      for (int i = 0; i < 4; i++)
      begin
         d = {i[0], ~i[0], 2'b10, i[1:0], i[1], 1'b1};
         wr(8'h00, d);
         check("range", {7'h00, lf}, {7'h00, d[7]});
         check("lane map", {7'h00, map}, {7'h00, d[6]});
         check("mode", {6'h00, mode}, {6'h00, d[3:2]});
         check("sleep", {7'h00, slp}, {7'h00, d[1]});
         check("drive on", {7'h00, drv}, 8'h00);
         rd(8'h00, d, "reg0 back");
      end
      for (int c = 0; c < 8; c++)
      begin
         d = {4'hE, c[0], c[2:0]};
         wr(8'h02, d);
         check("fallback_osc_freq_sel", {5'h00, osc}, {5'h00, d[2:0]});
         check("swing", {7'h00, vod}, {7'h00, d[3]});
         check("osc out", {7'h00, osc_en}, {7'h00, c != 0});
         rd(8'h02, d, "reg2 back");
      end
      wr(8'h02, 8'h95);
      check("sleep sel", {7'h00, sss}, 8'h00);
      check("osc off", {7'h00, osc_en}, 8'h00);
      $display("test registers done");
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h01, {1'b1, ids[k]});
         cur = ids[k];
         check("reg addr", {1'b0, baddr}, {1'b0, ids[k]});
         rd(8'h01, {1'b1, ids[k]}, "reg1 back");
      end
      begin
         logic a;
         i_host.start();
         i_host.send({7'h73, 1'b0}, a);
         check("old addr", {7'h00, a}, 8'h00);
         i_host.stop();
      end
      wr(8'h01, 8'h72);
      cur = 7'h73;
      check("strap again", {1'b0, baddr}, 8'h73);
      $display("test address done");
      wr(8'h00, 8'h04);
      check("pins back", {6'h00, mode}, 8'h03);
      pd_n = 1'b0;
      {p_mode, strap, cur} = {2'h1, 2'h0, 7'h71};
      repeat (8) @(negedge sys_clk);
      check("pd mode", {6'h00, mode}, 8'h01);
      pd_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      check("pd strap", {1'b0, baddr}, 8'h71);
      rd(8'h01, 8'h70, "reg1 after pd");
      $display("test power down done");
      report_and_stop();
   end
endmodule
